// ### pkg/bias_ladder_pkg.sv
// Constants and register map of the LCD bias ladder power control
package bias_ladder_pkg;

	localparam int          CLK_HZ          = 10_000_000;
	localparam int          LCD_CLK_HZ      = 32_768;
	localparam int          TICK_CYCLES_INT = CLK_HZ / LCD_CLK_HZ;
	localparam logic [8:0]  TICK_LAST       = 9'(TICK_CYCLES_INT - 1);

	localparam logic [4:0]  PERIOD_A_LAST   = 5'h0F;
	localparam logic [4:0]  PERIOD_B_LAST   = 5'h1F;

	localparam logic [11:0] LADDER_OFFSET   = 12'h000;
	localparam logic [11:0] REF_OFFSET      = 12'h004;
	localparam logic [11:0] CONTRAST_OFFSET = 12'h008;
	localparam logic [11:0] CONFIG_OFFSET   = 12'h00C;
	localparam logic [11:0] STATUS_OFFSET   = 12'h010;

	localparam logic [7:0]  LADDER_RESET    = 8'h00;
	localparam logic [7:0]  LADDER_MASK     = 8'hF7;
	localparam logic [7:0]  REF_RESET       = 8'h00;
	localparam logic [7:0]  REF_MASK        = 8'hEE;
	localparam logic [2:0]  CONTRAST_RESET  = 3'h0;
	localparam logic [2:0]  CONFIG_RESET    = 3'h0;

	// Ladder control fields
	localparam int          A_PWR_LSB       = 6;
	localparam int          B_PWR_LSB       = 4;
	localparam int          RESERVED_BIT    = 3;
	localparam int          A_LEN_LSB       = 0;

	// Reference control fields
	localparam int          REF_ENABLE_BIT  = 7;
	localparam int          REF_SOURCE_BIT  = 6;
	localparam int          REF_IDLE_BIT    = 5;
	localparam int          PIN3_BIT        = 3;
	localparam int          PIN2_BIT        = 2;
	localparam int          PIN1_BIT        = 1;

	// Config fields
	localparam int          HALF_BIAS_BIT   = 0;
	localparam int          STATIC_BIAS_BIT = 1;
	localparam int          WAVE_TYPE_BIT   = 2;

	typedef enum logic [1:0] {
		PWR_OFF,
		PWR_LOW,
		PWR_MEDIUM,
		PWR_HIGH
	} ladder_power_t;

endpackage : bias_ladder_pkg

// ### rtl/bias_ladder_ctrl.sv
// LCD bias ladder power sequencing, contrast and reference gating, APB slave
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module bias_ladder_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        lcd_active_flag,
	input  wire logic        seg_transition,
	output logic             ladder_connect,
	output logic             ladder_low_power,
	output logic             ladder_medium_power,
	output logic             ladder_high_power,
	output logic             ladder_mid_short,
	output logic             bias_tap_enable,
	output logic             power_mode_a,
	output logic      [2:0]  contrast_tap_sel,
	output logic             contrast_open,
	output logic             internal_ref_on,
	output logic             internal_ref_from_fvr,
	output logic             fvr_buffer_enable,
	output logic             fvr_request,
	output logic             bias1_pin_connect,
	output logic             bias2_pin_connect,
	output logic             bias3_pin_connect
);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0]  ladder_reg;
		logic [7:0]  ref_reg;
		logic [2:0]  contrast_reg;
		logic [2:0]  config_reg;
		logic [8:0]  div_cnt;
		logic [4:0]  presc;
		logic        mode_a;
		logic [1:0]  power;
		logic [2:0]  level;
		logic        connect;
		logic        mid_short;
		logic        taps;
		logic [2:0]  tap;
		logic        open;
		logic        ref_on;
		logic        ref_fvr;
		logic        buf_en;
		logic        fvr_req;
		logic [2:0]  pins;
		logic        ready;
		logic        err;
		logic [31:0] rdata;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic          tick;
	logic          mapped;
	logic [4:0]    period_last;
	logic [4:0]    presc_n;
	logic [2:0]    a_len;
	logic          mode_a_n;
	logic [1:0]    pwr_sel;
	logic          ref_en;
	logic          ref_src;
	logic          ref_idle;
	logic [31:0]   rd_val;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		a_len   = st_reg.ladder_reg[bias_ladder_pkg::A_LEN_LSB +: 3];
		ref_en  = st_reg.ref_reg[bias_ladder_pkg::REF_ENABLE_BIT];
		ref_src = st_reg.ref_reg[bias_ladder_pkg::REF_SOURCE_BIT];
		ref_idle = st_reg.ref_reg[bias_ladder_pkg::REF_IDLE_BIT];

		// 32 kHz enable from the bus clock
		tick = (st_reg.div_cnt == bias_ladder_pkg::TICK_LAST);
		if (tick) begin
			st_next.div_cnt = '0;
		end else begin
			st_next.div_cnt = st_reg.div_cnt + 9'h001;
		end

		// Prescaler period follows the waveform type
		if (st_reg.config_reg[bias_ladder_pkg::WAVE_TYPE_BIT]) begin
			period_last = bias_ladder_pkg::PERIOD_B_LAST;
		end else begin
			period_last = bias_ladder_pkg::PERIOD_A_LAST;
		end

		// Transition restarts the count so mode A aligns to the edge
		if (!lcd_active_flag || seg_transition) begin
			presc_n = '0;
		end else if (tick) begin
			if (st_reg.presc >= period_last) begin
				presc_n = '0;
			end else begin
				presc_n = st_reg.presc + 5'h01;
			end
		end else begin
			presc_n = st_reg.presc;
		end
		st_next.presc = presc_n;

		// Zero length keeps B; otherwise first n counts are A
		mode_a_n = lcd_active_flag && (a_len != 3'h0)
		           && (presc_n < {2'b00, a_len});
		st_next.mode_a = mode_a_n;

		if (mode_a_n) begin
			pwr_sel = st_reg.ladder_reg[bias_ladder_pkg::A_PWR_LSB +: 2];
		end else begin
			pwr_sel = st_reg.ladder_reg[bias_ladder_pkg::B_PWR_LSB +: 2];
		end
		if (!lcd_active_flag) begin
			pwr_sel = bias_ladder_pkg::PWR_OFF;
		end
		st_next.power   = pwr_sel;
		st_next.level   = {pwr_sel == bias_ladder_pkg::PWR_HIGH,
		                   pwr_sel == bias_ladder_pkg::PWR_MEDIUM,
		                   pwr_sel == bias_ladder_pkg::PWR_LOW};
		st_next.connect = (pwr_sel != bias_ladder_pkg::PWR_OFF);

		// Static bias needs no intermediate taps; half bias shorts the middle
		st_next.taps = st_next.connect
		    && !st_reg.config_reg[bias_ladder_pkg::STATIC_BIAS_BIT];
		st_next.mid_short = st_next.taps
		    && st_reg.config_reg[bias_ladder_pkg::HALF_BIAS_BIT];

		// Contrast needs an active module and a selected reference
		st_next.tap     = st_reg.contrast_reg;
		st_next.open    = !lcd_active_flag || !ref_en;
		st_next.ref_on  = lcd_active_flag && ref_en;
		st_next.ref_fvr = st_next.ref_on && ref_src;
		st_next.fvr_req = st_next.ref_fvr;
		// Buffer may sleep in mode B, where the ladder draws little
		st_next.buf_en  = st_next.ref_fvr && !(ref_idle && !mode_a_n);

		// Pins are independent of the ladder so both can be used together
		st_next.pins = {st_reg.ref_reg[bias_ladder_pkg::PIN3_BIT],
		                st_reg.ref_reg[bias_ladder_pkg::PIN2_BIT],
		                st_reg.ref_reg[bias_ladder_pkg::PIN1_BIT]};

		// Register decode
		mapped = 1'b1;
		rd_val = '0;
		case (paddr)
			bias_ladder_pkg::LADDER_OFFSET: begin
				rd_val[7:0] = st_reg.ladder_reg;
			end
			bias_ladder_pkg::REF_OFFSET: begin
				rd_val[7:0] = st_reg.ref_reg;
			end
			bias_ladder_pkg::CONTRAST_OFFSET: begin
				rd_val[2:0] = st_reg.contrast_reg;
			end
			bias_ladder_pkg::CONFIG_OFFSET: begin
				rd_val[2:0] = st_reg.config_reg;
			end
			bias_ladder_pkg::STATUS_OFFSET: begin
				rd_val[0]   = lcd_active_flag;
				rd_val[1]   = st_reg.mode_a;
				rd_val[3:2] = st_reg.power;
				rd_val[8:4] = st_reg.presc;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase

		// One wait state: ready rises in the second access cycle
		st_next.ready = 1'b0;
		if (psel && penable && !st_reg.ready) begin
			st_next.ready = 1'b1;
			st_next.err   = !mapped;
			st_next.rdata = pwrite ? 32'h0000_0000 : rd_val;
		end

		// Write lands on the edge where ready is sampled
		if (psel && penable && st_reg.ready && pwrite && mapped) begin
			case (paddr)
				bias_ladder_pkg::LADDER_OFFSET: begin
					st_next.ladder_reg = pwdata[7:0]
					    & bias_ladder_pkg::LADDER_MASK;
				end
				bias_ladder_pkg::REF_OFFSET: begin
					st_next.ref_reg = pwdata[7:0] & bias_ladder_pkg::REF_MASK;
				end
				bias_ladder_pkg::CONTRAST_OFFSET: begin
					st_next.contrast_reg = pwdata[2:0];
				end
				bias_ladder_pkg::CONFIG_OFFSET: begin
					st_next.config_reg = pwdata[2:0];
				end
				default: begin
					st_next.config_reg = st_reg.config_reg;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg              <= '0;
			st_reg.ladder_reg   <= bias_ladder_pkg::LADDER_RESET;
			st_reg.ref_reg      <= bias_ladder_pkg::REF_RESET;
			st_reg.contrast_reg <= bias_ladder_pkg::CONTRAST_RESET;
			st_reg.config_reg   <= bias_ladder_pkg::CONFIG_RESET;
			st_reg.open         <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata                = st_reg.rdata;
	assign pready                = st_reg.ready;
	assign pslverr               = st_reg.err;
	assign ladder_connect        = st_reg.connect;
	assign ladder_low_power      = st_reg.level[0];
	assign ladder_medium_power   = st_reg.level[1];
	assign ladder_high_power     = st_reg.level[2];
	assign ladder_mid_short      = st_reg.mid_short;
	assign bias_tap_enable       = st_reg.taps;
	assign power_mode_a          = st_reg.mode_a;
	assign contrast_tap_sel      = st_reg.tap;
	assign contrast_open         = st_reg.open;
	assign internal_ref_on       = st_reg.ref_on;
	assign internal_ref_from_fvr = st_reg.ref_fvr;
	assign fvr_buffer_enable     = st_reg.buf_en;
	assign fvr_request           = st_reg.fvr_req;
	assign bias1_pin_connect     = st_reg.pins[0];
	assign bias2_pin_connect     = st_reg.pins[1];
	assign bias3_pin_connect     = st_reg.pins[2];

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_inactive;
		!lcd_active_flag;
	endsequence

	sequence seq_edge_with_a;
		seg_transition && lcd_active_flag
		    && (st_reg.ladder_reg[2:0] != 3'h0);
	endsequence

	sequence seq_wrap_a;
		tick && lcd_active_flag && !seg_transition
		    && !st_reg.config_reg[bias_ladder_pkg::WAVE_TYPE_BIT]
		    && (st_reg.presc == 5'h0F);
	endsequence

	sequence seq_pass_16;
		tick && lcd_active_flag && !seg_transition
		    && st_reg.config_reg[bias_ladder_pkg::WAVE_TYPE_BIT]
		    && (st_reg.presc == 5'h0F);
	endsequence

	AST_LADDER_OFF_INACTIVE: assert property (
		seq_inactive |=> !ladder_connect && !ladder_low_power
		    && !ladder_medium_power && !ladder_high_power)
		else $error("ladder powered while lcd inactive");

	AST_CONTRAST_OPEN: assert property (
		seq_inactive |=> contrast_open)
		else $error("contrast ladder closed while lcd inactive");

	AST_REF_OFF: assert property (
		seq_inactive |=> !internal_ref_on && !fvr_request)
		else $error("internal reference on while lcd inactive");

	AST_A_AT_EDGE: assert property (
		seq_edge_with_a |=> power_mode_a)
		else $error("mode A not entered at transition");

	AST_ZERO_LENGTH_B: assert property (
		(st_reg.ladder_reg[2:0] == 3'h0) |=> !power_mode_a)
		else $error("mode A with zero interval");

	AST_WRAP_16: assert property (
		seq_wrap_a |=> (st_reg.presc == 5'h00) && power_mode_a
		    == ($past(st_reg.ladder_reg[2:0]) != 3'h0))
		else $error("period of 16 not kept");

	AST_RUN_32: assert property (
		seq_pass_16 |=> (st_reg.presc == 5'h10) && !power_mode_a)
		else $error("period of 32 not kept");

	AST_BUFFER_IDLE: assert property (
		fvr_buffer_enable && $past(
		    st_reg.ref_reg[bias_ladder_pkg::REF_IDLE_BIT])
		    |-> power_mode_a)
		else $error("fixed reference buffer on in idle mode B");

	AST_RESERVED_READ: assert property (
		pready && !pslverr
		    && ($past(paddr) == bias_ladder_pkg::LADDER_OFFSET)
		    |-> !prdata[bias_ladder_pkg::RESERVED_BIT])
		else $error("reserved ladder bit read as one");

	AST_READY_PULSE: assert property (
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	AST_READY_WAIT: assert property (
		psel && penable && !pready |=> pready)
		else $error("ready not after one wait state");

	AST_HALF_SHORT: assert property (
		bias_tap_enable && $past(
		    st_reg.config_reg[bias_ladder_pkg::HALF_BIAS_BIT])
		    |-> ladder_mid_short)
		else $error("middle resistor not shorted in half bias");

	AST_STATIC_NO_TAPS: assert property (
		bias_tap_enable |-> ladder_connect && !$past(
		    st_reg.config_reg[bias_ladder_pkg::STATIC_BIAS_BIT]))
		else $error("intermediate taps used in static bias");

	AST_LEVEL_ONE_HOT: assert property (
		$onehot0({ladder_high_power, ladder_medium_power,
		    ladder_low_power}))
		else $error("more than one ladder power level");

	AST_POWER_A: assert property (
		power_mode_a |-> (st_reg.power == $past(
		    st_reg.ladder_reg[bias_ladder_pkg::A_PWR_LSB +: 2])))
		else $error("interval A power not applied");

	AST_POWER_B: assert property (
		!power_mode_a && $past(lcd_active_flag)
		    |-> (st_reg.power == $past(
		    st_reg.ladder_reg[bias_ladder_pkg::B_PWR_LSB +: 2])))
		else $error("interval B power not applied");

	AST_TAP_COPY: assert property (
		contrast_tap_sel == $past(st_reg.contrast_reg))
		else $error("contrast tap differs from field");

	AST_NO_REF_OPEN: assert property (
		!$past(st_reg.ref_reg[bias_ladder_pkg::REF_ENABLE_BIT])
		    |-> contrast_open)
		else $error("contrast closed without internal reference");

	AST_REF_SOURCE: assert property (
		internal_ref_from_fvr |-> internal_ref_on && $past(
		    st_reg.ref_reg[bias_ladder_pkg::REF_SOURCE_BIT]))
		else $error("fixed reference source without source bit");

	AST_FVR_REQUEST: assert property (
		internal_ref_from_fvr || fvr_buffer_enable |-> fvr_request)
		else $error("fixed reference not requested when needed");

	AST_PIN_COPY: assert property (
		{bias3_pin_connect, bias2_pin_connect, bias1_pin_connect}
		    == $past({st_reg.ref_reg[bias_ladder_pkg::PIN3_BIT],
		    st_reg.ref_reg[bias_ladder_pkg::PIN2_BIT],
		    st_reg.ref_reg[bias_ladder_pkg::PIN1_BIT]}))
		else $error("bias pin connect differs from its enable");

	AST_PRESC_STEP: assert property (
		tick && lcd_active_flag && !seg_transition
		    && (st_reg.presc < period_last)
		    |=> (st_reg.presc == $past(st_reg.presc) + 5'h01))
		else $error("prescaler did not advance on tick");

	AST_PRESC_HOLD: assert property (
		!tick && lcd_active_flag && !seg_transition
		    |=> $stable(st_reg.presc))
		else $error("prescaler moved without tick");

	AST_RESTART: assert property (
		seg_transition |=> (st_reg.presc == '0))
		else $error("interval count not restarted at transition");

endmodule : bias_ladder_ctrl

`default_nettype wire

// ### dv/lcd_panel_model.sv
// Behavioural LCD panel side: module activity and segment edges
`timescale 1ns/10ps
`default_nettype none

module lcd_panel_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic active_req,
	input  wire logic kick,
	output logic      lcd_active_flag,
	output logic      seg_transition
);
	// Edges are one-cycle pulses and only occur while the panel is driven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcd_active_flag <= 1'b0;
			seg_transition  <= 1'b0;
		end else begin
			lcd_active_flag <= active_req;
			seg_transition  <= kick & active_req;
		end
	end
endmodule : lcd_panel_model

`default_nettype wire

// ### dv/lcd_bias_ladder_power_control_tb.sv
// Self-checking bench for the LCD bias ladder power control
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] %0t value differs from expected", $time); end end

module lcd_bias_ladder_power_control_tb;
	localparam int          TICK = bias_ladder_pkg::TICK_CYCLES_INT;
	localparam logic [11:0] LAD  = bias_ladder_pkg::LADDER_OFFSET;
	localparam logic [11:0] REF  = bias_ladder_pkg::REF_OFFSET;
	localparam logic [11:0] CST  = bias_ladder_pkg::CONTRAST_OFFSET;
	localparam logic [11:0] CFG  = bias_ladder_pkg::CONFIG_OFFSET;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, active_req = 1'b0, kick = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, err, lcd_active_flag, seg_transition;
	logic        ladder_connect, ladder_low_power, ladder_medium_power;
	logic        ladder_high_power, ladder_mid_short, bias_tap_enable;
	logic        power_mode_a, contrast_open, internal_ref_on;
	logic        internal_ref_from_fvr, fvr_buffer_enable, fvr_request;
	logic        bias1_pin_connect, bias2_pin_connect, bias3_pin_connect;
	logic [2:0]  contrast_tap_sel, pwr, pins;
	logic [1:0]  c;
	int          n_mismatch = 0, n_checks = 0, ln;

	assign pwr  = {ladder_high_power, ladder_medium_power, ladder_low_power};
	assign pins = {bias3_pin_connect, bias2_pin_connect, bias1_pin_connect};

	always #50 pclk = ~pclk;

	bias_ladder_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .lcd_active_flag,
		.seg_transition, .ladder_connect, .ladder_low_power,
		.ladder_medium_power, .ladder_high_power, .ladder_mid_short,
		.bias_tap_enable, .power_mode_a, .contrast_tap_sel, .contrast_open,
		.internal_ref_on, .internal_ref_from_fvr, .fvr_buffer_enable,
		.fvr_request, .bias1_pin_connect, .bias2_pin_connect,
		.bias3_pin_connect);

	lcd_panel_model panel (.pclk, .presetn, .active_req, .kick,
		.lcd_active_flag, .seg_transition);

	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		`CHK(k, 2)
	endtask : apb

	// Write lands at the ready edge; outputs follow one edge later
	task automatic settle();
		repeat (2) @(posedge pclk);
	endtask : settle

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask : rd

	// Pulse lands two stages later; allow the registered outputs to settle
	task automatic pulse();
		@(posedge pclk);
		kick <= 1'b1;
		@(posedge pclk);
		kick <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : pulse

	task automatic wait_a(input logic v);
		ln = 0;
		while (power_mode_a !== v && ln < 20000) begin
			@(posedge pclk);
			ln++;
		end
	endtask : wait_a

	function automatic logic [2:0] oh(input logic [1:0] p);
		return (p == 2'h0) ? 3'h0 : 3'h1 << (p - 2'h1);
	endfunction : oh

	// Interval A is high power, B low power; both lengths are tick exact
	task automatic interval(input logic waveform_type_sel, input logic [2:0] n);
		int per;
		per = waveform_type_sel ? 32 : 16;
		apb(1'b1, CFG, {29'h0, waveform_type_sel, 2'h0});
		apb(1'b1, LAD, {24'h0, 4'hD, 1'b0, n});
		pulse();
		`CHK(power_mode_a, 1'b1)
		`CHK(fvr_buffer_enable, 1'b1)
		wait_a(1'b0);
		repeat (2) @(posedge pclk);
		`CHK(pwr, 3'h1)
		`CHK(fvr_buffer_enable, 1'b0)
		wait_a(1'b1);
		`CHK(ln + 2, (per - n) * TICK)
		repeat (2) @(posedge pclk);
		`CHK(pwr, 3'h4)
		wait_a(1'b0);
		`CHK(ln + 2, n * TICK)
		pulse();
		`CHK(power_mode_a, 1'b1)
	endtask : interval

	task wrap_up;
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge pclk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		repeat (20) @(posedge pclk);
		`CHK(contrast_open, 1'b1)
		presetn    <= 1'b1;
		active_req <= 1'b1;
		rd(LAD, 32'h0);
		apb(1'b1, LAD, 32'hFF);
		rd(LAD, 32'hF7);
		apb(1'b0, 12'h014, 32'h0);
		`CHK(err, 1'b1)
		`CHK(q, 32'h0)
		apb(1'b1, CFG, 32'h1);
		settle();
		`CHK(ladder_mid_short, 1'b1)
		`CHK(bias_tap_enable, 1'b1)
		apb(1'b1, CFG, 32'h2);
		settle();
		`CHK(bias_tap_enable, 1'b0)
		apb(1'b1, REF, 32'h82);
		settle();
		`CHK(pins, 3'h1)
		`CHK({internal_ref_on, internal_ref_from_fvr}, 2'h2)
		`CHK(fvr_request, 1'b0)
		apb(1'b1, CST, 32'h0F);
		rd(CST, 32'h07);
		`CHK(contrast_tap_sel, 3'h7)
		`CHK(contrast_open, 1'b0)
		apb(1'b1, REF, 32'h0);
		settle();
		`CHK(contrast_open, 1'b1)
		apb(1'b1, REF, 32'hFF);
		rd(REF, 32'hEE);
		`CHK(pins, 3'h7)
		`CHK({internal_ref_on, internal_ref_from_fvr}, 2'h3)
		`CHK(fvr_request, 1'b1)
		interval(1'b0, 3'h2);
		interval(1'b1, 3'h7);
		apb(1'b1, LAD, 32'hD0);
		pulse();
		wait_a(1'b1);
		`CHK(ln, 20000)
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			apb(1'b1, LAD, {24'h0, c, ~c, 4'h7});
			pulse();
			`CHK(pwr, oh(c))
			`CHK(ladder_connect, c != 2'h0)
			wait_a(1'b0);
			repeat (2) @(posedge pclk);
			`CHK(pwr, oh(~c))
		end
		@(posedge pclk);
		active_req <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK(ladder_connect, 1'b0)
		`CHK(contrast_open, 1'b1)
		`CHK(internal_ref_on, 1'b0)
		// Mid-run reset must bring the ladder and reference registers back to their reset values
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd(LAD, 32'h0);
		rd(REF, 32'h0);
		wrap_up();
	end
endmodule : lcd_bias_ladder_power_control_tb

`default_nettype wire
